//--- core/dpt_pkg.sv
// Package: register map, field layout and bus carrier for the dual timer
package dpt_pkg;

	// Timer count and register widths
	localparam int NUM_TIMERS = 2;
	localparam int CNT_W      = 16;
	localparam int BYTE_W     = 8;
	localparam int ADDR_W     = 8;
	localparam int DIV_W      = 17;

	// Register bus request carrier; cfg selects the configuration space
	typedef struct packed {
		logic              cfg;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} dpt_bus_req_t;

	typedef logic [ADDR_W-1:0] dpt_addr_t;
	typedef dpt_addr_t dpt_pair_t [NUM_TIMERS];

	// Output (write-only) space, index = timer
	localparam dpt_pair_t OUT_CMP_HI = '{8'h07, 8'h0b};
	localparam dpt_pair_t OUT_CMP_LO = '{8'h08, 8'h0c};
	localparam dpt_pair_t OUT_REL_HI = '{8'h09, 8'h0d};
	localparam dpt_pair_t OUT_REL_LO = '{8'h0a, 8'h0e};

	// Configuration (read/write) space
	localparam dpt_pair_t CFG_MAIN   = '{8'h09, 8'h0c};
	localparam dpt_pair_t CFG_WAVE   = '{8'h0a, 8'h0d};

	// Input (read-only) space
	localparam dpt_pair_t IN_CNT_HI  = '{8'h15, 8'h1a};
	localparam dpt_pair_t IN_CNT_LO  = '{8'h16, 8'h1b};
	localparam dpt_pair_t IN_STATE   = '{8'h17, 8'h1c};
	localparam dpt_pair_t IN_CAP_HI  = '{8'h18, 8'h1d};
	localparam dpt_pair_t IN_CAP_LO  = '{8'h19, 8'h1e};

	// Main control field positions
	localparam int MAIN_FUNC   = 7;
	localparam int MAIN_IRQ_S  = 6;
	localparam int MAIN_IRQ_F  = 5;
	localparam int MAIN_IRQ_R  = 4;
	localparam int MAIN_RUN    = 2;
	localparam int MAIN_HOLD   = 0;
	localparam logic [7:0] MAIN_MASK = 8'hf5;

	// Wave/prescale control field positions
	localparam int WAVE_SHAPE  = 5;
	localparam int EXP_W       = 5;
	localparam logic [7:0] WAVE_MASK = 8'h3f;
	localparam logic [EXP_W-1:0] EXP_MAX = 5'h10;

	// Status field positions
	localparam int ST_WRAP     = 3;
	localparam int ST_PIN      = 2;
	localparam int ST_RELEASED = 1;
	localparam int ST_RUNNING  = 0;

	// Reset values and counter constants
	localparam logic [BYTE_W-1:0] RST_BYTE   = 8'h00;
	localparam logic [BYTE_W-1:0] RST_REL_B  = 8'hff;
	localparam logic [CNT_W-1:0]  RST_CNT    = 16'h0000;
	localparam logic [CNT_W-1:0]  RST_REL    = 16'hffff;
	localparam logic [CNT_W-1:0]  CNT_MAX    = 16'hffff;
	localparam logic [CNT_W-1:0]  CNT_ONE    = 16'h0001;
	localparam logic [DIV_W-1:0]  DIV_ONE    = 17'h00001;
	localparam logic [DIV_W-1:0]  DIV_ZERO   = 17'h00000;

endpackage : dpt_pkg

//--- core/dpt_timer_regs.sv
// Dual 16-bit PWM/timer with its byte-wide register interface
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dpt_timer_regs
	import dpt_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_nrst,
	// Register bus
	input  wire dpt_bus_req_t          i_bus,
	output logic [BYTE_W-1:0]          o_rdata,
	// Timer output pins
	input  wire logic [NUM_TIMERS-1:0] i_wave_pin,
	output logic [NUM_TIMERS-1:0]      o_wave_pin,
	output logic [NUM_TIMERS-1:0]      o_wave_pin_oe,
	// Interrupt request pulses toward the system controller
	output logic [NUM_TIMERS-1:0]      o_irq_req
);

	// Address match for one space, used by both write and read decode
	function automatic logic hit(input dpt_bus_req_t b, input logic cfg,
		input dpt_addr_t a);
		hit = (b.cfg == cfg) && (b.addr == a);
	endfunction : hit

	// Per-timer state
	logic [BYTE_W-1:0] ctl_main   [NUM_TIMERS];
	logic [BYTE_W-1:0] ctl_wave   [NUM_TIMERS];
	logic [BYTE_W-1:0] cmp_hi_buf [NUM_TIMERS];
	logic [BYTE_W-1:0] rel_hi_buf [NUM_TIMERS];
	logic [CNT_W-1:0]  cmp_shadow [NUM_TIMERS];
	logic [CNT_W-1:0]  cmp_act    [NUM_TIMERS];
	logic [CNT_W-1:0]  reload     [NUM_TIMERS];
	logic [CNT_W-1:0]  count      [NUM_TIMERS];
	logic [CNT_W-1:0]  capture    [NUM_TIMERS];
	logic [DIV_W-1:0]  div_cnt    [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] wrap_flag;
	logic [NUM_TIMERS-1:0] wave;
	logic [NUM_TIMERS-1:0] wave_q;
	logic [NUM_TIMERS-1:0] run_q;
	logic [NUM_TIMERS-1:0] pin_meta;
	logic [NUM_TIMERS-1:0] pin_sync;
	logic [NUM_TIMERS-1:0] released;
	logic [NUM_TIMERS-1:0] running;
	logic [NUM_TIMERS-1:0] tick;
	logic [NUM_TIMERS-1:0] stop_evt;
	logic [BYTE_W-1:0]     next_rdata;

	// Pin level synchroniser; only the second stage feeds the status
	// pin level sync
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= i_wave_pin;
			pin_sync <= pin_meta;
		end
	end

	genvar t;
	generate
		for (t = 0; t < NUM_TIMERS; t++)
		begin : g_tmr
			logic [EXP_W-1:0] exp_c;
			logic [DIV_W-1:0] div_mask;
			logic             pwm_mode;
			logic             period_end;
			logic [CNT_W-1:0] count_inc;

			// hold bit low keeps the timer in reset
			assign released[t] = ctl_main[t][MAIN_HOLD];
			// function bit picks PWM, which ignores start/stop
			assign pwm_mode = ctl_main[t][MAIN_FUNC];
			// run bit gates counting in timer function
			assign running[t] = released[t] &
				(pwm_mode | ctl_main[t][MAIN_RUN]);

			// exponent clamped so an illegal value cannot overflow
			assign exp_c = (ctl_wave[t][EXP_W-1:0] > EXP_MAX) ?
				EXP_MAX : ctl_wave[t][EXP_W-1:0];
			assign div_mask = (DIV_ONE << exp_c) - DIV_ONE;
			assign tick[t] = running[t] &&
				((div_cnt[t] & div_mask) == div_mask);

			assign count_inc = count[t] + CNT_ONE;
			// Reload below two still gives a one-tick period
			assign period_end = pwm_mode ?
				(count_inc >= reload[t]) : (count[t] == cmp_act[t]);

			// Stop event: run bit dropped while released in timer function
			assign stop_evt[t] = released[t] & ~pwm_mode & run_q[t] &
				~ctl_main[t][MAIN_RUN];

			// Configuration registers, unused bits masked off
			// unused bits dropped
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst)
				begin
					ctl_main[t] <= RST_BYTE;
					ctl_wave[t] <= RST_BYTE;
				end
				else if (i_bus.wr && hit(i_bus, 1'b1, CFG_MAIN[t]))
					ctl_main[t] <= i_bus.wdata & MAIN_MASK;
				else if (i_bus.wr && hit(i_bus, 1'b1, CFG_WAVE[t]))
					ctl_wave[t] <= i_bus.wdata & WAVE_MASK;
			end

			// Compare pair: high byte waits, low byte commits to shadow
			// high byte buffered
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst)
				begin
					cmp_hi_buf[t] <= RST_BYTE;
					cmp_shadow[t] <= RST_CNT;
				end
				else if (i_bus.wr && hit(i_bus, 1'b0, OUT_CMP_HI[t]))
					cmp_hi_buf[t] <= i_bus.wdata;
				else if (i_bus.wr && hit(i_bus, 1'b0, OUT_CMP_LO[t]))
					cmp_shadow[t] <= {cmp_hi_buf[t], i_bus.wdata};
			end

			// Reload pair: committed on low byte and used at once
			// reload low commits
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst)
				begin
					rel_hi_buf[t] <= RST_REL_B;
					reload[t]     <= RST_REL;
				end
				else if (i_bus.wr && hit(i_bus, 1'b0, OUT_REL_HI[t]))
					rel_hi_buf[t] <= i_bus.wdata;
				else if (i_bus.wr && hit(i_bus, 1'b0, OUT_REL_LO[t]))
					reload[t] <= {rel_hi_buf[t], i_bus.wdata};
			end

			// Prescaler: free count, cleared while held or stopped
			// power-of-two divider
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst || !running[t])
					div_cnt[t] <= DIV_ZERO;
				else
					div_cnt[t] <= div_cnt[t] + DIV_ONE;
			end

			// Counter, active compare and waveform
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst || !released[t])
				begin
					count[t]   <= RST_CNT;
					cmp_act[t] <= cmp_shadow[t];
					wave[t]    <= 1'b0;
				end
				else if (!running[t])
					// Idle: a pending compare loads before the next start
					cmp_act[t] <= cmp_shadow[t];
				else if (tick[t])
				begin
					if (period_end)
					begin
						count[t]   <= RST_CNT;
						// compare swaps only at phase end
						cmp_act[t] <= cmp_shadow[t];
						if (pwm_mode)
							// high at period start unless compare is zero
							wave[t] <= (cmp_shadow[t] != RST_CNT);
						else if (ctl_wave[t][WAVE_SHAPE])
							wave[t] <= ~wave[t];
						else
							wave[t] <= 1'b1;
					end
					else
					begin
						count[t] <= count_inc;
						if (pwm_mode && count_inc == cmp_act[t])
							wave[t] <= 1'b0;
						else if (!pwm_mode && !ctl_wave[t][WAVE_SHAPE])
							wave[t] <= 1'b0;
					end
				end
			end

			// Wrap flag: sticky until timer or device reset
			// set on wrap from max
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst || !released[t])
					wrap_flag[t] <= 1'b0;
				else if (tick[t] && count[t] == CNT_MAX)
					wrap_flag[t] <= 1'b1;
			end

			// Capture on stop; holds until the next stop or device reset
			// capture on stop
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst)
					capture[t] <= RST_CNT;
				else if (stop_evt[t])
					capture[t] <= count[t];
			end

			// Edge history for events and stop detection
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst)
				begin
					wave_q[t] <= 1'b0;
					run_q[t]  <= 1'b0;
				end
				else
				begin
					wave_q[t] <= wave[t];
					run_q[t]  <= ctl_main[t][MAIN_RUN];
				end
			end

			// Interrupt requests, each source under its own enable
			// three gated sources
			always_ff @(posedge i_clk)
			begin
				if (!i_nrst)
					o_irq_req[t] <= 1'b0;
				else
					o_irq_req[t] <=
						(stop_evt[t] & ctl_main[t][MAIN_IRQ_S]) |
						(wave_q[t] & ~wave[t] & ctl_main[t][MAIN_IRQ_F]) |
						(~wave_q[t] & wave[t] & ctl_main[t][MAIN_IRQ_R]);
			end

			// Pin drive; left floating while the timer is held in reset
			assign o_wave_pin[t]    = wave[t];
			assign o_wave_pin_oe[t] = released[t];
		end
	endgenerate

	// Read decode; output space and unmapped addresses read zero
	always_comb
	begin
		next_rdata = RST_BYTE;
		for (int k = 0; k < NUM_TIMERS; k++)
		begin
			if (hit(i_bus, 1'b1, CFG_MAIN[k]))
				next_rdata = ctl_main[k];
			else if (hit(i_bus, 1'b1, CFG_WAVE[k]))
				next_rdata = ctl_wave[k];
			else if (hit(i_bus, 1'b0, IN_CNT_HI[k]))
				next_rdata = count[k][CNT_W-1:BYTE_W];
			else if (hit(i_bus, 1'b0, IN_CNT_LO[k]))
				next_rdata = count[k][BYTE_W-1:0];
			else if (hit(i_bus, 1'b0, IN_STATE[k]))
			begin
				next_rdata[ST_WRAP]     = wrap_flag[k];
				next_rdata[ST_PIN]      = pin_sync[k];
				next_rdata[ST_RELEASED] = released[k];
				next_rdata[ST_RUNNING]  = running[k];
			end
			else if (hit(i_bus, 1'b0, IN_CAP_HI[k]))
				next_rdata = capture[k][CNT_W-1:BYTE_W];
			else if (hit(i_bus, 1'b0, IN_CAP_LO[k]))
				next_rdata = capture[k][BYTE_W-1:0];
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst || !i_bus.rd)
			o_rdata <= RST_BYTE;
		else
			o_rdata <= next_rdata;
	end

endmodule : dpt_timer_regs

`default_nettype wire

//--- testbench/dpt_timer_regs_chk.sv
// Concurrent checks on the dual timer register block ports
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_regs_chk
	import dpt_pkg::*;
(
	// Clock, reset and register bus
	input  wire logic                  i_clk,
	input  wire logic                  i_nrst,
	input  wire dpt_bus_req_t          i_bus,
	input  wire logic [BYTE_W-1:0]     o_rdata,
	// Timer pins and requests
	input  wire logic [NUM_TIMERS-1:0] i_wave_pin,
	input  wire logic [NUM_TIMERS-1:0] o_wave_pin,
	input  wire logic [NUM_TIMERS-1:0] o_wave_pin_oe,
	input  wire logic [NUM_TIMERS-1:0] o_irq_req
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	// Timer 1 main control accesses and a steady high pin
	sequence s_wr_main;
		i_bus.wr && i_bus.cfg && i_bus.addr == 8'h0c;
	endsequence
	sequence s_rd_main;
		i_bus.rd && i_bus.cfg && i_bus.addr == 8'h0c;
	endsequence
	sequence s_pin_hi;
		i_wave_pin[1] [*4];
	endsequence

	property p_rd_idle;
		!$past(i_bus.rd) |-> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not idle");
	property p_stat_hi;
		i_bus.rd && !i_bus.cfg && (i_bus.addr == 8'h17 ||
			i_bus.addr == 8'h1c) |=> o_rdata[7:4] == 4'h0;
	endproperty
	a_stat_hi: assert property (p_stat_hi)
		else $error("status unused bits set");
	property p_out_zero;
		i_bus.rd && !i_bus.cfg && i_bus.addr <= 8'h14 |=> o_rdata == 8'h00;
	endproperty
	a_out_zero: assert property (p_out_zero)
		else $error("write-only space read not zero");
	property p_cfg_back;
		s_wr_main ##2 s_rd_main |=>
			o_rdata == ($past(i_bus.wdata, 3) & MAIN_MASK);
	endproperty
	a_cfg_back: assert property (p_cfg_back)
		else $error("main control readback wrong");
	property p_hold_oe;
		s_wr_main ##0 !i_bus.wdata[0] |-> ##[1:2] !o_wave_pin_oe[1];
	endproperty
	a_hold_oe: assert property (p_hold_oe)
		else $error("pin enabled while held");
	property p_rel_oe;
		s_wr_main ##0 i_bus.wdata[0] |-> ##[1:2] o_wave_pin_oe[1];
	endproperty
	a_rel_oe: assert property (p_rel_oe)
		else $error("pin not enabled after release");
	property p_held_low;
		!o_wave_pin_oe[1] [*2] |-> !o_wave_pin[1];
	endproperty
	a_held_low: assert property (p_held_low)
		else $error("wave high while held");
	property p_pin;
		s_pin_hi ##0 (i_bus.rd && !i_bus.cfg && i_bus.addr == 8'h1c)
			|=> o_rdata[2];
	endproperty
	a_pin: assert property (p_pin)
		else $error("pin level not reported");
endmodule : dpt_timer_regs_chk
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the dual timer register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb
	import dpt_pkg::*;
;
	logic                  i_clk = 1'b0;
	logic                  i_nrst = 1'b0;
	dpt_bus_req_t          bus = '0;
	logic [NUM_TIMERS-1:0] pin = '0;
	logic [BYTE_W-1:0]     rdata;
	logic [NUM_TIMERS-1:0] wave;
	logic [NUM_TIMERS-1:0] oe;
	logic [NUM_TIMERS-1:0] irq;
	int                    miscompares = 0;
	int                    checks = 0;
	int                    nirq [NUM_TIMERS] = '{0, 0};

	dpt_timer_regs uut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
		.i_wave_pin(pin), .o_wave_pin(wave), .o_wave_pin_oe(oe),
		.o_irq_req(irq)
	);

	// 250 MHz clock and request pulse counters
	initial forever #2 i_clk = ~i_clk;
	always @(posedge i_clk) foreach (nirq[k]) nirq[k] += int'(irq[k]);

	// Bus cycles; a gap cycle avoids driving the bus twice in one step
	task automatic wr(input logic c, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		bus <= '{c, a, d, 1'b1, 1'b0};
		@(posedge i_clk);
		bus <= '0;
	endtask : wr
	task automatic rd(input logic c, input logic [7:0] a, output logic [7:0] q);
		@(posedge i_clk);
		bus <= '{c, a, 8'h00, 1'b0, 1'b1};
		@(posedge i_clk);
		bus <= '0;
		#1 q = rdata;
	endtask : rd
	task automatic rdc(input logic c, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		rd(c, a, q);
		`CHK(q, e)
	endtask : rdc

	task automatic t_reset;
		for (int t = 0; t < NUM_TIMERS; t++)
		begin
			rdc(1'b1, CFG_MAIN[t], 8'h00);
			rdc(1'b1, CFG_WAVE[t], 8'h00);
			for (logic [7:0] a = IN_CNT_HI[t]; a <= IN_CAP_LO[t]; a++)
				rdc(1'b0, a, 8'h00);
		end
		rdc(1'b0, OUT_CMP_HI[0], 8'h00);
		rdc(1'b0, 8'h1f, 8'h00);
	endtask : t_reset

	task automatic t_cfg;
		for (int t = 0; t < NUM_TIMERS; t++)
		begin
			wr(1'b1, CFG_MAIN[t], 8'hfe);
			rdc(1'b1, CFG_MAIN[t], 8'hf4);
			`CHK(oe[t], 1'b0)
			wr(1'b1, CFG_WAVE[t], 8'hf0);
			rdc(1'b1, CFG_WAVE[t], 8'h30);
			wr(1'b1, CFG_MAIN[t], 8'h05);
			rdc(1'b0, IN_STATE[t], 8'h03);
			wr(1'b1, CFG_MAIN[t], 8'h01);
			rdc(1'b0, IN_STATE[t], 8'h02);
			`CHK(oe[t], 1'b1)
		end
	endtask : t_cfg

	// PWM reload 4, compare 2: two high ticks of four; e picks edge enables
	task automatic t_pwm(input int t, input logic [1:0] e);
		logic [NUM_TIMERS-1:0] prev;
		int                    hi;
		int                    ed;
		int                    x;
		x = int'(e[0]);
		hi = 0;
		ed = 0;
		wr(1'b1, CFG_MAIN[t], 8'h00);
		wr(1'b0, OUT_REL_HI[t], 8'h00);
		wr(1'b0, OUT_REL_LO[t], 8'h04);
		wr(1'b0, OUT_CMP_HI[t], 8'h00);
		wr(1'b0, OUT_CMP_LO[t], 8'h02);
		wr(1'b1, CFG_WAVE[t], 8'(x));
		wr(1'b1, CFG_MAIN[t], {2'b10, e, 4'h1});
		repeat (20) @(posedge i_clk);
		#1 prev = wave;
		nirq[t] = 0;
		repeat (8 << x)
		begin
			@(posedge i_clk);
			#1 hi += int'(wave[t]);
			ed += int'(wave[t] != prev[t]);
			prev = wave;
		end
		`CHK(hi, 4 << x)
		`CHK(ed, 4)
		`CHK(nirq[t], (e == 2'd3) ? 4 : ((e == 2'd0) ? 0 : 2))
		rdc(1'b0, IN_STATE[t], 8'h03);
	endtask : t_pwm

	// Timer function, compare 3: four-tick phases, square or pulse shape
	task automatic t_shape(input logic s);
		int   hi;
		int   ed;
		logic prev;
		hi = 0;
		ed = 0;
		wr(1'b1, CFG_MAIN[0], 8'h00);
		wr(1'b0, OUT_CMP_HI[0], 8'h00);
		wr(1'b0, OUT_CMP_LO[0], 8'h03);
		wr(1'b1, CFG_WAVE[0], {2'b00, s, 5'h00});
		wr(1'b1, CFG_MAIN[0], 8'h05);
		repeat (20) @(posedge i_clk);
		#1 prev = wave[0];
		repeat (16)
		begin
			@(posedge i_clk);
			#1 hi += int'(wave[0]);
			ed += int'(wave[0] != prev);
			prev = wave[0];
		end
		`CHK(hi, s ? 8 : 4)
		`CHK(ed, s ? 4 : 8)
	endtask : t_shape

	// Timer mode run past the counter maximum, then stop and hold
	task automatic t_wrap;
		logic [7:0] c [4];
		wr(1'b1, CFG_MAIN[1], 8'h00);
		wr(1'b1, CFG_WAVE[1], 8'h00);
		wr(1'b0, OUT_CMP_HI[1], 8'hff);
		wr(1'b0, OUT_CMP_LO[1], 8'hff);
		wr(1'b1, CFG_MAIN[1], 8'h45);
		repeat (66000) @(posedge i_clk);
		rdc(1'b0, IN_STATE[1], 8'h0b);
		nirq[1] = 0;
		wr(1'b1, CFG_MAIN[1], 8'h41);
		repeat (4) @(posedge i_clk);
		`CHK(nirq[1], 1)
		rdc(1'b0, IN_STATE[1], 8'h0a);
		rd(1'b0, IN_CAP_HI[1], c[0]);
		rd(1'b0, IN_CAP_LO[1], c[1]);
		rd(1'b0, IN_CNT_HI[1], c[2]);
		rd(1'b0, IN_CNT_LO[1], c[3]);
		`CHK({c[0], c[1]}, {c[2], c[3]})
		// Stopped 66004 ticks after release: one wrap, then 468 more
		`CHK({c[0], c[1]}, 16'h01d4)
		wr(1'b1, CFG_MAIN[1], 8'h40);
		rdc(1'b0, IN_STATE[1], 8'h00);
		rdc(1'b0, IN_CNT_LO[1], 8'h00);
	endtask : t_wrap

	task automatic t_pin;
		wr(1'b1, CFG_MAIN[0], 8'h00);
		@(posedge i_clk);
		pin <= 2'b10;
		repeat (4) @(posedge i_clk);
		rdc(1'b0, IN_STATE[1], 8'h04);
		rdc(1'b0, IN_STATE[0], 8'h00);
	endtask : t_pin

	task automatic stop_test;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// Main sequence after four reset cycles
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		t_reset();
		t_cfg();
		for (int t = 0; t < NUM_TIMERS; t++)
			for (int e = 0; e < 4; e++)
				t_pwm(t, 2'(e));
		t_shape(1'b0);
		t_shape(1'b1);
		t_wrap();
		t_pin();
		// Mid-run device reset must also clear the capture left by the wrap
		@(posedge i_clk);
		i_nrst <= 1'b0;
		pin    <= '0;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		t_reset();
		stop_test();
	end

	// Watchdog well past the long wrap run
	initial
	begin
		#400000;
		miscompares++;
		stop_test();
	end
endmodule : tb

bind dpt_timer_regs dpt_timer_regs_chk u_chk (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
	.i_wave_pin(i_wave_pin), .o_wave_pin(o_wave_pin),
	.o_wave_pin_oe(o_wave_pin_oe), .o_irq_req(o_irq_req)
);
`default_nettype wire
